// ---- verilog/pfs_cfg.svh ----
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PFS_OFS_PIPE4     5'h15
`define PFS_OFS_PIPE5     5'h16
`define PFS_OFS_STATUS    5'h17

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define PFS_WIDTH_MSB     5
`define PFS_WIDTH_RST     6'h00
`define PFS_ST_REUSE      6
`define PFS_ST_TX_FULL    5
`define PFS_ST_TX_EMPTY   4
`define PFS_ST_RX_FULL    1
`define PFS_ST_RX_EMPTY   0

// ----------------------------------------------------------------
// payload geometry and queue depths
// ----------------------------------------------------------------
`define PFS_PLD_BITS      256
`define PFS_LEN_BITS      6
`define PFS_PIPE_BITS     3
`define PFS_MAX_LEN       6'h20
`define PFS_MAX_PIPE      3'h5
`define PFS_PIPE4         3'h4
`define PFS_PIPE5         3'h5
`define PFS_Q_DEPTH       3
`define PFS_STAGE_DEPTH   16

`endif

// ---- verilog/pfs_pkg.sv ----
package pfs_pkg;
	// host commands, already decoded from the serial link
	typedef enum logic [2:0] {
		PFS_CMD_NONE     = 3'h0,
		PFS_CMD_WR_TX    = 3'h1,
		PFS_CMD_WR_ACK   = 3'h2,
		PFS_CMD_RD_RX    = 3'h3,
		PFS_CMD_REUSE    = 3'h4,
		PFS_CMD_FLUSH_TX = 3'h5,
		PFS_CMD_FLUSH_RX = 3'h6
	} pfs_cmd_t;
endpackage

// ---- verilog/pfs_fifo.sv ----
`timescale 1ns/1ps
module pfs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             flush,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	// occupancy flags
	output logic                  full,
	output logic                  empty
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];   // storage, no reset needed
	logic [AW-1:0]    wr_ptr_q;      // next slot to fill
	logic [AW-1:0]    rd_ptr_q;      // oldest slot
	logic [CW-1:0]    count_q;       // words held
	logic [CW-1:0]    count_d;
	logic             full_q;        // registered so ready is a flop
	logic             empty_q;
	logic             push;
	logic             pop;

	assign push      = in_valid && !full_q;
	assign pop       = out_ready && !empty_q;
	assign in_ready  = !full_q;
	assign out_valid = !empty_q;
	assign out_data  = mem[rd_ptr_q];
	assign full      = full_q;
	assign empty     = empty_q;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr_q] <= in_data;
		end
	end

	// pointers wrap explicitly, depth need not be a power of two
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else if (flush) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
			end
		end
	end

	// next occupancy
	always_comb begin
		count_d = count_q;
		if (push && !pop) begin
			count_d = count_q + CW'(1);
		end else if (pop && !push) begin
			count_d = count_q - CW'(1);
		end
	end

	// flags follow the occupancy in the same cycle it changes
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			count_q <= '0;
			full_q  <= 1'b0;
			empty_q <= 1'b1;
		end else if (flush) begin
			count_q <= '0;
			full_q  <= 1'b0;
			empty_q <= 1'b1;
		end else begin
			count_q <= count_d;
			full_q  <= (count_d == CW'(DEPTH));
			empty_q <= (count_d == '0);
		end
	end

	full_exact_a: assert property (@(posedge mclk) disable iff (rst)
		full_q == (count_q == CW'(DEPTH))) else $error("full flag not tied to depth");
	empty_exact_a: assert property (@(posedge mclk) disable iff (rst)
		empty_q == (count_q == '0)) else $error("empty flag not tied to zero count");
endmodule

// ---- verilog/pfs_payload_queues.sv ----
`timescale 1ns/1ps
`include "pfs_cfg.svh"

// Function
// - pipe 4/5 width field 5:0, 0..32
// - reuse flag repeats last packet while enabled
// - reuse set by reuse command, cleared by transmit write or transmit flush command
// - status bits 5/4 give transmit full/empty
// - status bits 1/0 give receive full/empty
// - at most three acknowledge payloads pending
// - same-pipe acknowledge payloads leave in order
// - acknowledge payloads loaded by command in either mode, served in receive mode only
// - three-entry transmit queue, loaded in either mode, sent in transmit mode only
// - one shared three-entry receive queue
module pfs_payload_queues #(
	parameter int QDEPTH      = `PFS_Q_DEPTH,
	parameter int STAGE_DEPTH = `PFS_STAGE_DEPTH
) (
	// clock and reset
	input  wire logic                      mclk,
	input  wire logic                      rst,
	// register access
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	input  wire logic [4:0]                reg_addr,
	input  wire logic [7:0]                reg_wdata,
	output logic      [7:0]                reg_rdata_q,
	// host payload commands
	input  wire logic                      cmd_valid,
	input  wire pfs_pkg::pfs_cmd_t         cmd_op,
	input  wire logic [`PFS_PIPE_BITS-1:0] cmd_pipe,
	input  wire logic [`PFS_LEN_BITS-1:0]  cmd_len,
	input  wire logic [`PFS_PLD_BITS-1:0]  cmd_data,
	// receive payload read answer
	output logic                           rx_rd_valid_q,
	output logic      [`PFS_LEN_BITS-1:0]  rx_rd_len_q,
	output logic      [`PFS_PLD_BITS-1:0]  rx_rd_data_q,
	// radio control
	input  wire logic                      ce_pin,
	input  wire logic                      prx_mode,
	// radio transmit side
	output logic                           tx_pkt_valid_q,
	input  wire logic                      tx_pkt_ready,
	output logic      [`PFS_LEN_BITS-1:0]  tx_pkt_len_q,
	output logic      [`PFS_PLD_BITS-1:0]  tx_pkt_data_q,
	// radio receive side
	input  wire logic                      rx_in_valid,
	output logic                           rx_in_ready_q,
	input  wire logic [`PFS_PIPE_BITS-1:0] rx_in_pipe,
	input  wire logic [`PFS_LEN_BITS-1:0]  rx_in_len,
	input  wire logic [`PFS_PLD_BITS-1:0]  rx_in_data,
	// radio acknowledge side
	input  wire logic                      ack_req,
	input  wire logic [`PFS_PIPE_BITS-1:0] ack_req_pipe,
	output logic                           ack_hit_q,
	output logic      [`PFS_LEN_BITS-1:0]  ack_len_q,
	output logic      [`PFS_PLD_BITS-1:0]  ack_data_q
);
	import pfs_pkg::*;

	localparam int WW = `PFS_PLD_BITS + `PFS_LEN_BITS;   // payload word with length
	localparam int AC = $clog2(QDEPTH + 1);

	// ----------------------------------------------------------------
	// decode and synchroniser
	// ----------------------------------------------------------------
	logic          ce_m_q;          // first stage, read only by ce_s_q
	logic          ce_s_q;          // radio enable in clock domain
	logic          len_ok;          // host payload length 1..32
	logic          do_wr_tx;
	logic          do_flush_tx;
	logic          do_flush_rx;
	logic          do_rd_rx;

	assign len_ok      = (cmd_len != '0) && (cmd_len <= `PFS_MAX_LEN);
	assign do_wr_tx    = cmd_valid && (cmd_op == PFS_CMD_WR_TX);
	assign do_flush_tx = cmd_valid && (cmd_op == PFS_CMD_FLUSH_TX);
	assign do_flush_rx = cmd_valid && (cmd_op == PFS_CMD_FLUSH_RX);
	assign do_rd_rx    = cmd_valid && (cmd_op == PFS_CMD_RD_RX);

	// enable pin arrives asynchronously
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ce_m_q <= 1'b0;
			ce_s_q <= 1'b0;
		end else begin
			ce_m_q <= ce_pin;
			ce_s_q <= ce_m_q;
		end
	end

	// ----------------------------------------------------------------
	// width registers
	// ----------------------------------------------------------------
	logic [`PFS_WIDTH_MSB:0] pipe4_width_q;   // 0 means pipe unused
	logic [`PFS_WIDTH_MSB:0] pipe5_width_q;
	logic [`PFS_WIDTH_MSB:0] wr_width;

	assign wr_width = reg_wdata[`PFS_WIDTH_MSB:0];

	// values above 32 are refused so the field never holds a bad count
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pipe4_width_q <= `PFS_WIDTH_RST;
			pipe5_width_q <= `PFS_WIDTH_RST;
		end else if (reg_wr && (wr_width <= `PFS_MAX_LEN)) begin
			if (reg_addr == `PFS_OFS_PIPE4) begin
				pipe4_width_q <= wr_width;
			end
			if (reg_addr == `PFS_OFS_PIPE5) begin
				pipe5_width_q <= wr_width;
			end
		end
	end

	// ----------------------------------------------------------------
	// transmit queue and reuse
	// ----------------------------------------------------------------
	logic          reuse_q;         // repeat last packet
	logic          have_last_q;     // a packet has gone out since flush
	logic [WW-1:0] last_q;          // last packet handed to the radio
	logic          txq_ready;
	logic          txq_valid;
	logic [WW-1:0] txq_data;
	logic          txq_full;
	logic          txq_empty;
	logic          tx_take;         // output stage can load
	logic          tx_go;           // radio allowed to transmit
	logic          txq_pop;

	assign tx_take = !tx_pkt_valid_q || tx_pkt_ready;
	assign tx_go   = ce_s_q && !prx_mode;
	assign txq_pop = tx_take && tx_go && !reuse_q && !do_flush_tx;

	pfs_fifo #(.WIDTH(WW), .DEPTH(QDEPTH)) u_txq (
		.mclk      (mclk),
		.rst       (rst),
		.flush     (do_flush_tx),
		.in_valid  (do_wr_tx && len_ok),
		.in_ready  (txq_ready),
		.in_data   ({cmd_len, cmd_data}),
		.out_valid (txq_valid),
		.out_ready (txq_pop),
		.out_data  (txq_data),
		.full      (txq_full),
		.empty     (txq_empty)
	);

	// reuse flag: host may only steer it by command
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reuse_q <= 1'b0;
		end else if (cmd_valid && (cmd_op == PFS_CMD_REUSE)) begin
			reuse_q <= 1'b1;
		end else if (do_wr_tx || do_flush_tx) begin
			reuse_q <= 1'b0;
		end
	end

	// output stage to the radio; reuse keeps feeding the last packet
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_pkt_valid_q <= 1'b0;
			tx_pkt_len_q   <= '0;
			tx_pkt_data_q  <= '0;
			last_q         <= '0;
			have_last_q    <= 1'b0;
		end else if (do_flush_tx) begin
			tx_pkt_valid_q <= 1'b0;
			have_last_q    <= 1'b0;
		end else if (tx_take) begin
			if (tx_go && reuse_q && have_last_q) begin
				tx_pkt_valid_q <= 1'b1;
				{tx_pkt_len_q, tx_pkt_data_q} <= last_q;
			end else if (txq_pop && txq_valid) begin
				tx_pkt_valid_q <= 1'b1;
				{tx_pkt_len_q, tx_pkt_data_q} <= txq_data;
				last_q         <= txq_data;
				have_last_q    <= 1'b1;
			end else begin
				tx_pkt_valid_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// receive staging buffer and shared receive queue
	// ----------------------------------------------------------------
	logic          rx_drop;         // packet for an unused pipe
	logic          stg_ready;
	logic          stg_valid;
	logic [WW-1:0] stg_data;
	logic          rxq_ready;
	logic          rxq_valid;
	logic [WW-1:0] rxq_data;
	logic          rxq_full;
	logic          rxq_empty;

	assign rx_drop = ((rx_in_pipe == `PFS_PIPE4) && (pipe4_width_q == '0)) ||
	                 ((rx_in_pipe == `PFS_PIPE5) && (pipe5_width_q == '0));
	assign rx_in_ready_q = stg_ready;   // registered inside the buffer

	// staging absorbs radio bursts; when it fills the radio is stalled
	pfs_fifo #(.WIDTH(WW), .DEPTH(STAGE_DEPTH)) u_stage (
		.mclk      (mclk),
		.rst       (rst),
		.flush     (do_flush_rx),
		.in_valid  (rx_in_valid && !rx_drop),
		.in_ready  (stg_ready),
		.in_data   ({rx_in_len, rx_in_data}),
		.out_valid (stg_valid),
		.out_ready (rxq_ready),
		.out_data  (stg_data),
		.full      (),
		.empty     ()
	);

	// all pipes share this queue; it stalls the staging buffer when full
	pfs_fifo #(.WIDTH(WW), .DEPTH(QDEPTH)) u_rxq (
		.mclk      (mclk),
		.rst       (rst),
		.flush     (do_flush_rx),
		.in_valid  (stg_valid),
		.in_ready  (rxq_ready),
		.in_data   (stg_data),
		.out_valid (rxq_valid),
		.out_ready (do_rd_rx),
		.out_data  (rxq_data),
		.full      (rxq_full),
		.empty     (rxq_empty)
	);

	// read answer: one-cycle pulse, invalid when queue was empty
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rx_rd_valid_q <= 1'b0;
			rx_rd_len_q   <= '0;
			rx_rd_data_q  <= '0;
		end else begin
			rx_rd_valid_q <= do_rd_rx && rxq_valid;
			if (do_rd_rx && rxq_valid) begin
				{rx_rd_len_q, rx_rd_data_q} <= rxq_data;
			end
		end
	end

	// ----------------------------------------------------------------
	// acknowledge payload slots, kept compacted oldest first
	// ----------------------------------------------------------------
	logic                      slot_v_q    [QDEPTH];
	logic [`PFS_PIPE_BITS-1:0] slot_pipe_q [QDEPTH];
	logic [WW-1:0]             slot_data_q [QDEPTH];
	logic [AC-1:0]             ack_cnt;
	logic [AC-1:0]             ack_idx;
	logic                      ack_found;
	logic                      ack_pop;
	logic                      ack_push;

	// lowest matching slot is the oldest for that pipe
	always_comb begin
		ack_cnt   = '0;
		ack_idx   = '0;
		ack_found = 1'b0;
		for (int i = QDEPTH - 1; i >= 0; i--) begin
			if (slot_v_q[i]) begin
				ack_cnt = ack_cnt + AC'(1);
			end
			if (slot_v_q[i] && (slot_pipe_q[i] == ack_req_pipe)) begin
				ack_found = 1'b1;
				ack_idx   = AC'(i);
			end
		end
	end

	assign ack_pop  = ack_req && prx_mode && ack_found;
	assign ack_push = cmd_valid && (cmd_op == PFS_CMD_WR_ACK) && len_ok &&
	                  (cmd_pipe <= `PFS_MAX_PIPE) && (ack_cnt < AC'(QDEPTH));

	// removal shifts younger slots down, so order per pipe is kept
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < QDEPTH; i++) begin
				slot_v_q[i]    <= 1'b0;
				slot_pipe_q[i] <= '0;
				slot_data_q[i] <= '0;
			end
		end else if (do_flush_tx && prx_mode) begin
			for (int i = 0; i < QDEPTH; i++) begin
				slot_v_q[i] <= 1'b0;
			end
		end else begin
			if (ack_pop) begin
				for (int i = 0; i < QDEPTH - 1; i++) begin
					if (AC'(i) >= ack_idx) begin
						slot_v_q[i]    <= slot_v_q[i+1];
						slot_pipe_q[i] <= slot_pipe_q[i+1];
						slot_data_q[i] <= slot_data_q[i+1];
					end
				end
				slot_v_q[QDEPTH-1] <= 1'b0;
			end
			if (ack_push) begin
				slot_v_q[ack_cnt - AC'(ack_pop)]    <= 1'b1;
				slot_pipe_q[ack_cnt - AC'(ack_pop)] <= cmd_pipe;
				slot_data_q[ack_cnt - AC'(ack_pop)] <= {cmd_len, cmd_data};
			end
		end
	end

	// answer to the radio one cycle after its request
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ack_hit_q  <= 1'b0;
			ack_len_q  <= '0;
			ack_data_q <= '0;
		end else begin
			ack_hit_q <= ack_pop;
			if (ack_pop) begin
				{ack_len_q, ack_data_q} <= slot_data_q[ack_idx];
			end
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	// reserved bits read as zero; unmapped offsets read zero
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata_q <= 8'h00;
			if (reg_addr == `PFS_OFS_PIPE4) begin
				reg_rdata_q[`PFS_WIDTH_MSB:0] <= pipe4_width_q;
			end
			if (reg_addr == `PFS_OFS_PIPE5) begin
				reg_rdata_q[`PFS_WIDTH_MSB:0] <= pipe5_width_q;
			end
			if (reg_addr == `PFS_OFS_STATUS) begin
				reg_rdata_q[`PFS_ST_REUSE]    <= reuse_q;
				reg_rdata_q[`PFS_ST_TX_FULL]  <= txq_full;
				reg_rdata_q[`PFS_ST_TX_EMPTY] <= txq_empty;
				reg_rdata_q[`PFS_ST_RX_FULL]  <= rxq_full;
				reg_rdata_q[`PFS_ST_RX_EMPTY] <= rxq_empty;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	width_range_a: assert property (@(posedge mclk) disable iff (rst)
		(pipe4_width_q <= `PFS_MAX_LEN) && (pipe5_width_q <= `PFS_MAX_LEN)) else $error("width above 32");
	reuse_repeat_a: assert property (@(posedge mclk) disable iff (rst)
		tx_take && tx_go && reuse_q && have_last_q && !do_flush_tx |=>
		tx_pkt_valid_q && ({tx_pkt_len_q, tx_pkt_data_q} == last_q)) else $error("reuse did not repeat");
	reuse_set_a: assert property (@(posedge mclk) disable iff (rst)
		cmd_valid && (cmd_op == PFS_CMD_REUSE) |=> reuse_q) else $error("reuse not set");
	reuse_clear_a: assert property (@(posedge mclk) disable iff (rst)
		do_wr_tx || do_flush_tx |=> !reuse_q) else $error("reuse not cleared");
	tx_status_a: assert property (@(posedge mclk) disable iff (rst)
		reg_rd && (reg_addr == `PFS_OFS_STATUS) |=>
		reg_rdata_q[`PFS_ST_TX_FULL] == $past(txq_full) &&
		reg_rdata_q[`PFS_ST_TX_EMPTY] == $past(txq_empty)) else $error("tx status bits wrong");
	rx_status_a: assert property (@(posedge mclk) disable iff (rst)
		reg_rd && (reg_addr == `PFS_OFS_STATUS) |=>
		reg_rdata_q[`PFS_ST_RX_FULL] == $past(rxq_full) &&
		reg_rdata_q[`PFS_ST_RX_EMPTY] == $past(rxq_empty)) else $error("rx status bits wrong");
	ack_limit_a: assert property (@(posedge mclk) disable iff (rst)
		ack_cnt == AC'(QDEPTH) && !ack_pop && !(do_flush_tx && prx_mode) |=>
		ack_cnt == AC'(QDEPTH)) else $error("ack slot overfilled");
	ack_oldest_a: assert property (@(posedge mclk) disable iff (rst)
		ack_req && prx_mode && slot_v_q[0] && (slot_pipe_q[0] == ack_req_pipe) |=>
		ack_hit_q && ({ack_len_q, ack_data_q} == $past(slot_data_q[0]))) else $error("ack order broken");
	ack_rx_only_a: assert property (@(posedge mclk) disable iff (rst)
		ack_hit_q |-> $past(prx_mode)) else $error("ack served outside receive mode");
	tx_mode_only_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(tx_pkt_valid_q) |-> $past(ce_s_q) && !$past(prx_mode)) else $error("tx outside transmit mode");
	rx_read_a: assert property (@(posedge mclk) disable iff (rst)
		do_rd_rx && !rxq_empty |=>
		rx_rd_valid_q && ({rx_rd_len_q, rx_rd_data_q} == $past(rxq_data))) else $error("rx read lost");
endmodule

// ---- tb/pfs_radio_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// radio stand-in taking offered packets
// ----------------------------------------
module pfs_radio_model (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// pacing: slow stalls every other cycle
	input  wire logic         slow,
	// transmit offer from the block
	input  wire logic         tx_pkt_valid_q,
	input  wire logic [255:0] tx_pkt_data_q,
	output logic              tx_pkt_ready
);
	logic [255:0] seen[$]; // accepted packets, oldest first
	// ready pacing; a slow radio tests held offers
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_pkt_ready <= 1'b0;
		end else begin
			tx_pkt_ready <= slow ? ~tx_pkt_ready : 1'b1;
		end
	end
	// log each handshake for the bench
	always @(posedge mclk) begin
		if (!rst && tx_pkt_valid_q && tx_pkt_ready) begin
			seen.push_back(tx_pkt_data_q);
		end
	end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 256'(e), 256'(g))
module tb_top;
	import pfs_pkg::*;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic         mclk = 0, rst = 1, slow = 0;
	logic         reg_wr = 0, reg_rd = 0, cmd_valid = 0, ce_pin = 0, prx_mode = 0;
	logic [4:0]   reg_addr = 0;
	logic [7:0]   reg_wdata = 0, reg_rdata_q;
	pfs_cmd_t     cmd_op = PFS_CMD_NONE;
	logic [2:0]   cmd_pipe = 0, rx_in_pipe = 0, ack_req_pipe = 0;
	logic [5:0]   cmd_len = 0, rx_in_len = 0, rx_rd_len_q, tx_pkt_len_q, ack_len_q;
	logic [255:0] cmd_data = 0, rx_in_data = 0, rx_rd_data_q, tx_pkt_data_q, ack_data_q;
	logic         rx_rd_valid_q, tx_pkt_valid_q, tx_pkt_ready, rx_in_valid = 0, rx_in_ready_q;
	logic         ack_req = 0, ack_hit_q;
	int           miscompares = 0, num_checks = 0, cyc = 0, k, i;
	logic [7:0]   d;
	// 10 MHz core clock
	always #50 mclk = ~mclk;
	pfs_payload_queues #(.QDEPTH(3), .STAGE_DEPTH(16)) u_pfs_payload_queues (.mclk, .rst, .reg_wr, .reg_rd,
		.reg_addr, .reg_wdata, .reg_rdata_q, .cmd_valid, .cmd_op, .cmd_pipe, .cmd_len, .cmd_data,
		.rx_rd_valid_q, .rx_rd_len_q, .rx_rd_data_q, .ce_pin, .prx_mode, .tx_pkt_valid_q, .tx_pkt_ready,
		.tx_pkt_len_q, .tx_pkt_data_q, .rx_in_valid, .rx_in_ready_q, .rx_in_pipe, .rx_in_len, .rx_in_data,
		.ack_req, .ack_req_pipe, .ack_hit_q, .ack_len_q, .ack_data_q);
	pfs_radio_model u_pfs_radio_model (.mclk, .rst, .slow, .tx_pkt_valid_q, .tx_pkt_data_q, .tx_pkt_ready);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [255:0] pat(input logic [7:0] v);
		return {32{v}};
	endfunction
	task check(input string n, input logic [255:0] e, input logic [255:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task close_out;
		if (miscompares == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// hang guard: whole run is a few hundred cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 4000) begin
			miscompares++;
			close_out;
		end
	end
	// register strobes last exactly one sampling edge
	task rw(input logic [4:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task rr(input logic [4:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_rd <= 1'b1; reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 `CHK("register read", e, reg_rdata_q);
	endtask
	// status read after occupancy has settled
	task st(input logic [7:0] e);
		repeat (2) @(posedge mclk);
		rr(5'h17, e);
	endtask
	task cmd(input pfs_cmd_t op, input logic [2:0] p, input logic [7:0] v);
		@(posedge mclk);
		cmd_valid <= 1'b1; cmd_op <= op; cmd_pipe <= p; cmd_len <= 6'h20; cmd_data <= pat(v);
		@(posedge mclk);
		cmd_valid <= 1'b0;
	endtask
	// radio delivers one packet; released data is scrambled
	task rx_send(input logic [2:0] p, input logic [7:0] v);
		@(posedge mclk);
		rx_in_valid <= 1'b1; rx_in_pipe <= p; rx_in_len <= 6'h20; rx_in_data <= pat(v);
		@(posedge mclk);
		for (k = 0; k < 50 && !rx_in_ready_q; k++) @(posedge mclk);
		rx_in_valid <= 1'b0;
		rx_in_data <= ~pat(v);
	endtask
	task ack(input logic [2:0] p, input logic h, input logic [7:0] v);
		@(posedge mclk);
		ack_req <= 1'b1; ack_req_pipe <= p;
		@(posedge mclk);
		ack_req <= 1'b0;
		#1 `CHK("ack hit", h, ack_hit_q);
		if (h) `CHK("ack data", pat(v), ack_data_q);
		if (h) `CHK("ack len", 6'h20, ack_len_q);
	endtask
	task wait_seen(input int n);
		for (k = 0; k < 200 && u_pfs_radio_model.seen.size() < n; k++) @(posedge mclk);
		`CHK("tx count", 1, u_pfs_radio_model.seen.size() >= n);
		`CHK("tx len", 6'h20, tx_pkt_len_q);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		st(8'h11);
		`CHK("rx ready", 1, rx_in_ready_q);
		rr(5'h15, 8'h00);
		rr(5'h16, 8'h00);
		rw(5'h15, 8'h20);
		rr(5'h15, 8'h20);
		rw(5'h15, 8'h21);
		rr(5'h15, 8'h20);
		rw(5'h16, 8'hC5);
		rr(5'h16, 8'h05);
		rr(5'h10, 8'h00);
		// transmit queue fill, refuse, drain
		for (i = 1; i <= 3; i++) begin
			cmd(PFS_CMD_WR_TX, 3'h0, 8'(i));
			st(i == 3 ? 8'h21 : 8'h01);
		end
		cmd(PFS_CMD_WR_TX, 3'h0, 8'h04);
		rw(5'h17, 8'hFF);
		st(8'h21);
		@(posedge mclk);
		ce_pin <= 1'b1;
		wait_seen(3);
		for (i = 1; i <= 3; i++) `CHK("tx order", pat(8'(i)), u_pfs_radio_model.seen.pop_front());
		st(8'h11);
		// reuse repeats the last packet under a slow radio
		@(posedge mclk);
		ce_pin <= 1'b0;
		cmd(PFS_CMD_REUSE, 3'h0, 8'h00);
		st(8'h51);
		@(posedge mclk);
		slow <= 1'b1;
		ce_pin <= 1'b1;
		wait_seen(4);
		for (i = 0; i < 4; i++) `CHK("reuse data", pat(8'h03), u_pfs_radio_model.seen.pop_front());
		ce_pin <= 1'b0;
		repeat (6) @(posedge mclk);
		// repeats must stop once the enable is low
		u_pfs_radio_model.seen.delete();
		repeat (6) @(posedge mclk);
		`CHK("reuse stop", 0, u_pfs_radio_model.seen.size());
		`CHK("tx idle", 0, tx_pkt_valid_q);
		cmd(PFS_CMD_WR_TX, 3'h0, 8'h05);
		st(8'h01);
		cmd(PFS_CMD_FLUSH_TX, 3'h0, 8'h00);
		st(8'h11);
		cmd(PFS_CMD_REUSE, 3'h0, 8'h00);
		cmd(PFS_CMD_FLUSH_TX, 3'h0, 8'h00);
		st(8'h11);
		// transmit queue stays put in receive mode
		@(posedge mclk);
		prx_mode <= 1'b1;
		ce_pin <= 1'b1;
		cmd(PFS_CMD_WR_TX, 3'h0, 8'h66);
		repeat (8) @(posedge mclk);
		`CHK("tx in rx mode", 0, u_pfs_radio_model.seen.size());
		ce_pin <= 1'b0;
		cmd(PFS_CMD_FLUSH_TX, 3'h0, 8'h00);
		// shared receive queue, overfilled then drained
		for (i = 1; i <= 4; i++) rx_send(3'(i), 8'(8'h10 + i));
		st(8'h12);
		for (i = 1; i <= 4; i++) begin
			cmd(PFS_CMD_RD_RX, 3'h0, 8'h00);
			#1 `CHK("rx valid", 1, rx_rd_valid_q);
			`CHK("rx data", pat(8'(8'h10 + i)), rx_rd_data_q);
			`CHK("rx len", 6'h20, rx_rd_len_q);
			repeat (4) @(posedge mclk);
		end
		st(8'h11);
		cmd(PFS_CMD_RD_RX, 3'h0, 8'h00);
		#1 `CHK("rx empty read", 0, rx_rd_valid_q);
		// flush empties the receive queue
		rx_send(3'h1, 8'h31);
		st(8'h10);
		cmd(PFS_CMD_FLUSH_RX, 3'h0, 8'h00);
		st(8'h11);
		rw(5'h15, 8'h00);
		rx_send(3'h4, 8'h77);
		repeat (8) @(posedge mclk);
		st(8'h11);
		// acknowledge slots: three pending, per-pipe order
		cmd(PFS_CMD_WR_ACK, 3'h2, 8'hA1);
		cmd(PFS_CMD_WR_ACK, 3'h3, 8'hB1);
		cmd(PFS_CMD_WR_ACK, 3'h2, 8'hA2);
		cmd(PFS_CMD_WR_ACK, 3'h2, 8'hA3);
		ack(3'h2, 1'b1, 8'hA1);
		ack(3'h2, 1'b1, 8'hA2);
		ack(3'h3, 1'b1, 8'hB1);
		ack(3'h2, 1'b0, 8'h00);
		cmd(PFS_CMD_WR_ACK, 3'h1, 8'hC1);
		prx_mode <= 1'b0;
		ack(3'h1, 1'b0, 8'h00);
		@(posedge mclk);
		prx_mode <= 1'b1;
		ack(3'h1, 1'b1, 8'hC1);
		close_out;
	end
endmodule
